// ### hdl/vpd_dispatch.sv
// Fetch-packet splitter, execute-packet dispatcher and simple execute
// stage for two sides of four functional units.
// Assumes program memory and data memory on sys_clk; data memory returns
// load data in the cycle after the request is shown.
`timescale 1ns/1ns
module vpd_dispatch (
  input  wire logic                                  sys_clk,
  input  wire logic                                  rst,
  output logic                                       fetch_req,
  input  wire logic                                  fetch_valid,
  input  wire logic [vpd_pkg::FETCH_W-1:0]           fetch_data,
  output vpd_pkg::vpd_issue_t [vpd_pkg::NUM_UNITS-1:0] unit_issue,
  output vpd_pkg::vpd_mem_t [1:0]                    mem_req,
  input  wire logic [1:0][31:0]                      mem_rdata,
  output logic                                       branch_valid,
  output logic [31:0]                                branch_target,
  output logic [1:0]                                 xpath_conflict
);
  import vpd_pkg::*;

  // Whole state of the dispatcher in one record
  typedef struct packed {
    logic [SLOTS-1:0][INSTR_W-1:0] pkt;   // Held fetch packet
    logic                          have;  // Packet held
    logic [2:0]                    ptr;   // First slot not yet issued
    vpd_issue_t [NUM_UNITS-1:0]    iss;   // Per-unit issue outputs
    vpd_mem_t [1:0]                mem;   // Data memory requests
    vpd_ldp_t [1:0]                ldp;   // Loads shown this cycle
    vpd_ldp_t [1:0]                ldw;   // Loads returning this cycle
    logic                          brv;   // Branch taken pulse
    logic [31:0]                   brt;   // Branch target
    logic [1:0]                    xcf;   // Cross path refused
  } vpd_disp_state_t;

  vpd_disp_state_t               s_q;     // Registered state
  vpd_disp_state_t               s_d;     // Next state
  vpd_wr_t [1:0][NUM_WP-1:0]     wr;      // Write ports, per side
  logic [1:0][NUM_REGS-1:0][31:0] rf;     // Register contents, per side
  logic                          fin_c;   // Last group of packet goes now

  // One register file per side
  generate
    for (genvar g = 0; g < 2; g++) begin : g_side
      vpd_regfile u_rf (
        .sys_clk (sys_clk),
        .rst     (rst),
        .wr      (wr[g]),
        .regs    (rf[g])
      );
    end
  endgenerate

  // Split, route and execute one execute packet per cycle
  always_comb begin
    logic                        open_c;  // Chain still running
    logic [3:0]                  last_c;  // Last slot of this group
    logic [2:0]                  u_c;     // Unit addressed by a slot
    logic [NUM_UNITS-1:0]        sel_v;   // Unit named in this group
    logic [NUM_UNITS-1:0][31:0]  sel_i;   // Instruction for that unit
    logic [1:0]                  xr_used; // Cross read taken, per side
    logic [1:0]                  xw_used; // Cross write taken, per side
    logic [31:0]                 ins;     // Instruction under work
    logic                        sd;      // Own side
    logic                        dsd;     // Destination side
    logic [1:0]                  ut;      // Unit kind
    logic [2:0]                  op;      // Operation code
    logic [3:0]                  dst;     // Destination register
    logic [31:0]                 s1;      // First operand
    logic [31:0]                 s2;      // Second operand
    logic                        xr;      // Reads over cross path
    logic                        xw;      // Writes over cross path
    logic [5:0]                  pe;      // Predicate table entry
    logic                        go;      // Instruction takes effect
    logic [31:0]                 res;     // Result
    logic [31:0]                 base;    // Address base
    logic [31:0]                 off;     // Scaled offset
    logic [31:0]                 sum;     // Linear address
    logic [31:0]                 addr;    // Final address
    logic [1:0]                  sz;      // Access size
    logic [31:0]                 dv;      // Store data or load data
    open_c  = s_q.have;
    last_c  = '0;
    u_c     = '0;
    sel_v   = '0;
    sel_i   = '0;
    xr_used = '0;
    xw_used = '0;
    ins     = '0;
    sd      = 1'b0;
    dsd     = 1'b0;
    ut      = '0;
    op      = '0;
    dst     = '0;
    s1      = '0;
    s2      = '0;
    xr      = 1'b0;
    xw      = 1'b0;
    pe      = '0;
    go      = 1'b0;
    res     = '0;
    base    = '0;
    off     = '0;
    sum     = '0;
    addr    = '0;
    sz      = '0;
    dv      = '0;
    wr      = '0;
    s_d     = s_q;
    s_d.brv = 1'b0;
    s_d.xcf = '0;
    s_d.mem = '0;
    s_d.ldp = '0;

    // Walk the slots from the pointer until the chain breaks
    for (int i = 0; i < SLOTS; i++) begin
      ins = s_q.pkt[i];
      if (open_c && (i >= int'(s_q.ptr))) begin
        last_c = 4'(i);
        // A cleared chain bit closes the group here
        if (!ins[F_CHAIN]) begin
          open_c = 1'b0;
        end
        // Slot seven closes regardless; packets never span anyway
        if (i == SLOTS - 1) begin
          open_c = 1'b0;
        end
        // Map slot to unit; a second claim on a unit is dropped
        u_c = {ins[F_SIDE], ins[F_UNIT +: 2]};
        if (!sel_v[u_c]) begin
          sel_v[u_c] = 1'b1;
          sel_i[u_c] = ins;
        end
      end
    end

    // Group done; the pointer moves to the slot after it
    fin_c = s_q.have && (last_c == 4'(SLOTS - 1));
    if (s_q.have) begin
      s_d.ptr = 3'(last_c + 4'h1);
    end
    if (fin_c) begin
      s_d.have = 1'b0;
    end

    // Take a new packet only when nothing is left to issue
    if ((!s_q.have || fin_c) && fetch_valid) begin
      s_d.have = 1'b1;
      s_d.ptr  = '0;
      s_d.pkt  = fetch_data;
    end

    // Per-unit issue and execute
    for (int u = 0; u < NUM_UNITS; u++) begin
      ins = sel_i[u];
      sd  = 1'(u >> 2);
      ut  = 2'(u);
      op  = ins[F_OP +: 3];
      dst = ins[F_DST +: 4];
      xw  = ins[F_XDST];
      xr  = ins[F_CROSS] && (ut != UNIT_DADDR);
      s1  = rf[sd][ins[F_SRC1 +: 4]];
      s2  = xr ? rf[!sd][ins[F_SRC2 +: 4]] : rf[sd][ins[F_SRC2 +: 4]];
      dsd = xw ? !sd : sd;
      // Idle units see a cleared valid
      s_d.iss[u].valid = sel_v[u];
      s_d.iss[u].instr = sel_v[u] ? ins : '0;
      // Predicate from a designated register, optionally inverted
      pe = PRED_TAB[ins[F_CREG +: 3]];
      go = sel_v[u] && (!pe[5] ||
           ((rf[pe[4]][pe[3:0]] != '0) ^ ins[F_Z]));
      // One cross read per side; a second one is refused
      if (go && xr) begin
        if (xr_used[sd]) begin
          go = 1'b0;
          s_d.xcf[sd] = 1'b1;
        end else begin
          xr_used[sd] = 1'b1;
        end
      end
      // One cross write per side; same treatment
      if (go && xw) begin
        if (xw_used[sd]) begin
          go = 1'b0;
          s_d.xcf[sd] = 1'b1;
        end else begin
          xw_used[sd] = 1'b1;
        end
      end
      unique case (ut)
        UNIT_LOGIC: begin
          case (op)
            OP_SUB:  res = s1 - s2;
            OP_AND:  res = s1 & s2;
            OP_OR:   res = s1 | s2;
            OP_XOR:  res = s1 ^ s2;
            OP_CMPL: res = {31'h0, $signed(s1) < $signed(s2)};
            default: res = s1 + s2;
          endcase
        end
        UNIT_SHBR: begin
          case (op)
            OP_SHL:  res = s1 << s2[4:0];
            OP_SHRU: res = s1 >> s2[4:0];
            OP_SHRA: res = 32'($signed(s1) >>> s2[4:0]);
            default: res = s1 + s2;
          endcase
          // Branch reports its target; first branching side wins
          if (go && op == OP_BR && !s_d.brv) begin
            s_d.brv = 1'b1;
            s_d.brt = s2;
          end
        end
        UNIT_MUL: begin
          // Only these two units carry a multiplier
          if (op == OP_MPYS) begin
            res = 32'($signed(s1[15:0]) * $signed(s2[15:0]));
          end else begin
            res = 32'(s1[15:0] * s2[15:0]);
          end
        end
        UNIT_DADDR: begin
          // Word size for code three keeps scaling in range
          sz   = (op[1:0] == 2'h3) ? SZ_WORD : op[1:0];
          base = ins[F_LONG] ? rf[sd][LONG_BASE] : s1;
          off  = ins[F_LONG] ? 32'(ins[F_OFF15 +: 15])
                             : 32'(ins[F_OFF5 +: 5]);
          off  = off << sz;
          sum  = base + off;
          // Circular mode wraps inside the masked block
          addr = (!ins[F_LONG] && ins[F_CIRC]) ?
                 ((base & ~CIRC_MASK) | (sum & CIRC_MASK)) : sum;
          dv   = rf[dsd][dst];
          res  = addr;
          if (go) begin
            // Base register takes the updated address
            wr[sd][WP_BASE] = '{we: 1'b1,
                                idx: ins[F_LONG] ? LONG_BASE
                                                 : ins[F_SRC1 +: 4],
                                data: addr};
            s_d.mem[sd].valid = 1'b1;
            s_d.mem[sd].store = op[F_STORE];
            s_d.mem[sd].addr  = addr;
            // Lanes by size and low address bits
            unique case (sz)
              SZ_BYTE: begin
                s_d.mem[sd].ben   = 4'(4'h1 << addr[1:0]);
                s_d.mem[sd].wdata = {4{dv[7:0]}};
              end
              SZ_HALF: begin
                s_d.mem[sd].ben   = 4'(4'h3 << {addr[1], 1'b0});
                s_d.mem[sd].wdata = {2{dv[15:0]}};
              end
              default: begin
                s_d.mem[sd].ben   = 4'hF;
                s_d.mem[sd].wdata = dv;
              end
            endcase
            if (!op[F_STORE]) begin
              // Load lands on the data side, maybe the other one
              s_d.ldp[sd] = '{valid: 1'b1, side: dsd, idx: dst,
                              size: sz, lane: addr[1:0]};
            end
          end
        end
      endcase
      // Plain result write, local port or the single cross port
      if (go && ut != UNIT_DADDR && !(ut == UNIT_SHBR && op == OP_BR)) begin
        if (xw) begin
          wr[dsd][WP_XWR] = '{we: 1'b1, idx: dst, data: res};
        end else begin
          wr[sd][ut] = '{we: 1'b1, idx: dst, data: res};
        end
      end
    end

    // Load data returns a cycle after the request was shown
    s_d.ldw = s_q.ldp;
    for (int d = 0; d < 2; d++) begin
      dv = mem_rdata[d] >> {s_q.ldw[d].lane, 3'h0};
      unique case (s_q.ldw[d].size)
        SZ_BYTE: dv = {24'h0, dv[7:0]};
        SZ_HALF: dv = {16'h0, dv[15:0]};
        default: dv = mem_rdata[d];
      endcase
      if (s_q.ldw[d].valid) begin
        wr[s_q.ldw[d].side][WP_LOAD + d] =
          '{we: 1'b1, idx: s_q.ldw[d].idx, data: dv};
      end
    end
  end

  // Registered state; reset forgets any half-issued packet
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  // Request while empty or while the final group leaves
  assign fetch_req      = !s_q.have || fin_c;
  assign unit_issue     = s_q.iss;
  assign mem_req        = s_q.mem;
  assign branch_valid   = s_q.brv;
  assign branch_target  = s_q.brt;
  assign xpath_conflict = s_q.xcf;
endmodule

// ### hdl/vpd_pkg.sv
// Constants, instruction field layout and carrier types shared by the
// execute-packet dispatcher and its register files.
// Assumes a single core clock and a program memory answering on the same clock.
// Overview of operation
// - Fetch packet is 256 bits, eight slots.
// - LSB one chains next instruction into packet.
// - LSB zero closes packet; next issues later.
// - Packet holds one to eight instructions, issued together; a second one for the same unit is dropped.
// - Any split into one to eight packets.
// - Exactly one execute packet issued per clock; the code issues none while no fetch packet is held.
// - Next fetch only after last packet issued.
// - Two sides, four unit kinds each.
// - Unnamed units get nothing and stay idle.
// - Each side owns sixteen 32-bit registers.
// - Same-side units all access registers each cycle.
// - One cross read, one cross write per side.
// - Address from one side loads other side.
// - Linear or circular update, 5/15-bit offsets.
// - Every instruction predicated; false means no effect.
// - Multiplies only on multiply units.
// - Loads and stores: byte, half-word, word.
package vpd_pkg;
  localparam int FETCH_W   = 256;  // Fetch packet width
  localparam int INSTR_W   = 32;   // Slot width
  localparam int SLOTS     = 8;    // Slots per fetch packet
  localparam int NUM_UNITS = 8;    // Functional units, both sides
  localparam int NUM_REGS  = 16;   // Registers per side
  localparam int NUM_WP    = 8;    // Write ports per register file
  // Write port map inside one register file
  localparam int WP_XWR    = 4;    // Cross write from the other side
  localparam int WP_BASE   = 5;    // Address update of local data unit
  localparam int WP_LOAD   = 6;    // Load returns, plus data unit side
  // Instruction field positions
  localparam int F_CHAIN   = 0;
  localparam int F_SIDE    = 1;
  localparam int F_UNIT    = 2;    // 2 bits
  localparam int F_OP      = 4;    // 3 bits
  localparam int F_CREG    = 7;    // 3 bits
  localparam int F_Z       = 10;
  localparam int F_DST     = 11;   // 4 bits
  localparam int F_LONG    = 15;
  localparam int F_XDST    = 16;
  localparam int F_CIRC    = 17;
  localparam int F_SRC1    = 18;   // 4 bits, base in short form
  localparam int F_SRC2    = 22;   // 4 bits
  localparam int F_OFF5    = 22;   // 5 bits
  localparam int F_CROSS   = 26;
  localparam int F_OFF15   = 17;   // 15 bits, long form
  localparam logic [3:0]  LONG_BASE = 4'hF;
  localparam logic [31:0] CIRC_MASK = 32'h000000FF;
  // Unit kinds
  typedef enum logic [1:0] {
    UNIT_LOGIC = 2'h0,
    UNIT_SHBR  = 2'h1,
    UNIT_MUL   = 2'h2,
    UNIT_DADDR = 2'h3
  } vpd_unit_t;
  // Operation codes
  localparam logic [2:0] OP_ADD  = 3'h0;
  localparam logic [2:0] OP_SUB  = 3'h1;
  localparam logic [2:0] OP_AND  = 3'h2;
  localparam logic [2:0] OP_OR   = 3'h3;
  localparam logic [2:0] OP_XOR  = 3'h4;
  localparam logic [2:0] OP_CMPL = 3'h5;
  localparam logic [2:0] OP_SHL  = 3'h0;
  localparam logic [2:0] OP_SHRU = 3'h1;
  localparam logic [2:0] OP_SHRA = 3'h2;
  localparam logic [2:0] OP_SADD = 3'h3;
  localparam logic [2:0] OP_BR   = 3'h4;
  localparam logic [2:0] OP_MPYS = 3'h1;
  localparam int         F_STORE = 2;      // Bit of op on data units
  localparam logic [1:0] SZ_BYTE = 2'h0;
  localparam logic [1:0] SZ_HALF = 2'h1;
  localparam logic [1:0] SZ_WORD = 2'h2;
  // Predicate table: {valid, side, register}
  localparam logic [7:0][5:0] PRED_TAB = {
    6'h00, 6'h00, 6'h32, 6'h31, 6'h30, 6'h22, 6'h21, 6'h00
  };
  typedef struct packed {
    logic       we;
    logic [3:0] idx;
    logic [31:0] data;
  } vpd_wr_t;
  typedef struct packed {
    logic        valid;
    logic [31:0] instr;
  } vpd_issue_t;
  typedef struct packed {
    logic        valid;
    logic        store;
    logic [3:0]  ben;
    logic [31:0] addr;
    logic [31:0] wdata;
  } vpd_mem_t;
  typedef struct packed {
    logic       valid;
    logic       side;
    logic [3:0] idx;
    logic [1:0] size;
    logic [1:0] lane;
  } vpd_ldp_t;
endpackage

// ### hdl/vpd_regfile.sv
// One side's register file with several write ports.
// Assumes writers on the same clock; a higher port wins on a clash.
`timescale 1ns/1ns
module vpd_regfile (
  input  wire logic                                 sys_clk,
  input  wire logic                                 rst,
  input  vpd_pkg::vpd_wr_t [vpd_pkg::NUM_WP-1:0]    wr,
  output logic [vpd_pkg::NUM_REGS-1:0][31:0]        regs
);
  import vpd_pkg::*;

  typedef struct packed {
    logic [NUM_REGS-1:0][31:0] r;   // Register contents
  } vpd_rf_state_t;

  vpd_rf_state_t s_q;               // Current contents
  vpd_rf_state_t s_d;               // Next contents

  // All ports land in one cycle; later ports override earlier ones
  always_comb begin
    s_d = s_q;
    for (int p = 0; p < NUM_WP; p++) begin
      if (wr[p].we) begin
        s_d.r[wr[p].idx] = wr[p].data;
      end
    end
  end

  // Cleared on reset so predicates without the z bit start false
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  // Reads are free for every unit, every cycle
  assign regs = s_q.r;
endmodule

// ### tb/vpd_dispatch_monitor.sv
// Port-level checker for the execute-packet dispatcher.
// Assumes one clock, synchronous active-high reset; bound at the file foot.
`timescale 1ns/1ns
module vpd_dispatch_monitor
  import vpd_pkg::*;
(
  input wire logic                                    sys_clk,
  input wire logic                                    rst,
  input wire logic                                    fetch_req,
  input wire logic                                    fetch_valid,
  input wire vpd_pkg::vpd_issue_t [vpd_pkg::NUM_UNITS-1:0] unit_issue,
  input wire vpd_pkg::vpd_mem_t [1:0]                 mem_req,
  input wire logic                                    branch_valid,
  input wire logic [1:0]                              xpath_conflict
);
  logic       any_issue;   // Some unit got an instruction
  logic       idle_dirty;  // Idle unit shows a non-zero word
  logic       bad_route;   // Instruction landed on the wrong unit
  logic [3:0] closers;     // Issued words with a clear chain bit

  // Summaries over all eight unit lanes
  always_comb begin
    any_issue  = 1'b0;
    idle_dirty = 1'b0;
    bad_route  = 1'b0;
    closers    = 4'h0;
    for (int i = 0; i < NUM_UNITS; i++) begin
      any_issue  |= unit_issue[i].valid;
      idle_dirty |= !unit_issue[i].valid && unit_issue[i].instr != 32'h0;
      bad_route  |= unit_issue[i].valid && {unit_issue[i].instr[F_SIDE],
                    unit_issue[i].instr[F_UNIT+:2]} != 3'(i);
      closers    += 4'(unit_issue[i].valid && !unit_issue[i].instr[F_CHAIN]);
    end
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  // Reset must leave the fetch side ready for a new packet
  property p_rst_req;
    @(posedge sys_clk) disable iff (1'b0) rst |=> fetch_req;
  endproperty
  a_rst_req: assert property (p_rst_req)
    else $error("fetch request low after reset");
  property p_first_group;
    fetch_req && fetch_valid |-> ##2 any_issue;
  endproperty
  a_first_group: assert property (p_first_group)
    else $error("no issue two cycles after a fetch");
  // A low request means groups are still waiting: one must go out
  property p_busy_issue;
    !fetch_req |=> any_issue;
  endproperty
  a_busy_issue: assert property (p_busy_issue)
    else $error("dispatcher busy but issued nothing");
  property p_idle_clean;
    !idle_dirty;
  endproperty
  a_idle_clean: assert property (p_idle_clean)
    else $error("idle unit shows an instruction word");
  property p_route;
    any_issue |-> !bad_route;
  endproperty
  a_route: assert property (p_route)
    else $error("instruction issued to the wrong unit");
  property p_one_closer;
    any_issue |-> closers <= 4'h1;
  endproperty
  a_one_closer: assert property (p_one_closer)
    else $error("group holds more than one closing word");
  property p_mem_src;
    (mem_req[0].valid -> unit_issue[3].valid) &&
    (mem_req[1].valid -> unit_issue[7].valid);
  endproperty
  a_mem_src: assert property (p_mem_src)
    else $error("memory access without a data unit issue");
  // Side-0 word stores must enable every byte lane
  property p_word_ben;
    mem_req[0].valid && mem_req[0].store && unit_issue[3].instr[5]
      |-> mem_req[0].ben == 4'hF;
  endproperty
  a_word_ben: assert property (p_word_ben)
    else $error("word store without all byte enables");
  property p_branch_src;
    branch_valid |->
      (unit_issue[1].valid && unit_issue[1].instr[6:4] == OP_BR) ||
      (unit_issue[5].valid && unit_issue[5].instr[6:4] == OP_BR);
  endproperty
  a_branch_src: assert property (p_branch_src)
    else $error("branch report without a branch issue");
  property p_xpath;
    |xpath_conflict |-> any_issue;
  endproperty
  a_xpath: assert property (p_xpath)
    else $error("cross path conflict without an issue");
endmodule
bind vpd_dispatch vpd_dispatch_monitor u_mon (.sys_clk, .rst, .fetch_req,
  .fetch_valid, .unit_issue, .mem_req, .branch_valid, .xpath_conflict);

// ### tb/vpd_prog_mem.sv
// Program and data memory stand-in for the dispatcher.
// Assumes inputs sampled settled at the falling edge; packets queued by push.
`timescale 1ns/1ns
module vpd_prog_mem (
  input  wire logic         sys_clk,
  input  wire logic         rst,
  input  wire logic         slow,
  input  wire logic         fetch_req,
  output logic              fetch_valid,
  output logic [255:0]      fetch_data,
  output logic [1:0][31:0]  mem_rdata
);
  logic [255:0] q[$];   // Packets waiting to be offered
  logic         take_n; // Offer will be taken at the coming edge
  logic         show;   // Offer for the coming cycle

  // Queue a whole packet; packets never split across offers
  task automatic push(input logic [255:0] p);
    q.push_back(p);
  endtask

  initial begin
    fetch_valid = 1'b0;
    fetch_data  = '0;
    mem_rdata   = '0;
    take_n      = 1'b0;
  end

  // Offer held until taken; lines churn when nothing is offered
  always @(negedge sys_clk) begin
    mem_rdata <= {$urandom, $urandom};
    if (rst) begin
      q.delete();
      show = 1'b0;
    end else if (take_n) begin
      void'(q.pop_front());
      show = 1'b0;
    end else begin
      show = fetch_valid;
    end
    // Slow mode inserts random gaps between offers
    if (!rst && !show && q.size() > 0 && (!slow || $urandom % 3 == 0))
      show = 1'b1;
    fetch_valid <= show;
    fetch_data  <= show ? q[0] : {8{$urandom}};
    take_n      <= show && fetch_req && !rst;
  end
endmodule

// ### tb/vpd_dispatch_test.sv
// Self-checking bench for the execute-packet dispatcher.
// Assumes the memory stand-in and the port checker in the same compile.
`timescale 1ns/1ns
module vpd_dispatch_test;
  import vpd_pkg::*;
  typedef vpd_issue_t [NUM_UNITS-1:0] vpd_grp_t;
  logic                 sys_clk;
  logic                 rst;
  logic                 slow;
  logic                 fetch_req;
  logic                 fetch_valid;
  logic [FETCH_W-1:0]   fetch_data;
  vpd_grp_t             unit_issue;
  vpd_mem_t [1:0]       mem_req;
  logic [1:0][31:0]     mem_rdata;
  logic                 branch_valid;
  logic [31:0]          branch_target;
  logic [1:0]           xpath_conflict;
  vpd_grp_t             exp_q[$];    // Groups still to be issued
  int                   miscompares;
  int                   n_compared;
  logic [7:0]           dir[5] = '{8'hFF, 8'h00, 8'h7F, 8'h55, 8'hFF};

  initial sys_clk = 1'b0;
  always #5 sys_clk = ~sys_clk;

  vpd_dispatch dut (.sys_clk, .rst, .fetch_req, .fetch_valid, .fetch_data,
    .unit_issue, .mem_req, .mem_rdata, .branch_valid,
    .branch_target, .xpath_conflict);
  vpd_prog_mem pm (.sys_clk, .rst, .slow, .fetch_req, .fetch_valid,
    .fetch_data, .mem_rdata);

  // One comparison, counted; mismatch printed at once
  task automatic check(input string what, input logic [263:0] seen, want);
    n_compared++;
    if (seen !== want) begin
      miscompares++;
      $display("wrong value %s: expected %h, seen %h", what, want, seen);
    end
  endtask

  task automatic close_out;
    if (miscompares == 0 && n_compared > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  // Random words with chosen chain bits; optionally all on one unit
  function automatic logic [255:0] mk_pkt(input logic [7:0] ch,
                                          input bit         same);
    logic [255:0] p;
    for (int s = 0; s < SLOTS; s++) begin
      p[32*s+:32] = $urandom;
      p[32*s] = ch[s];
      if (same) p[32*s+1+:3] = 3'h0;
    end
    return p;
  endfunction

  // Split into groups, lower slot wins a unit, slot seven always closes
  task automatic push_pkt(input logic [255:0] p);
    vpd_grp_t    g;
    logic [31:0] ins;
    logic [2:0]  u;
    g = '0;
    for (int s = 0; s < SLOTS; s++) begin
      ins = p[32*s+:32];
      u = {ins[F_SIDE], ins[F_UNIT+:2]};
      if (!g[u].valid) g[u] = {1'b1, ins};
      if (!ins[F_CHAIN] || s == SLOTS - 1) begin
        exp_q.push_back(g);
        g = '0;
      end
    end
    pm.push(p);
  endtask

  // Bounded wait until every queued group has been seen
  task automatic drain;
    for (int n = 0; n < 400 && exp_q.size() > 0; n++) @(negedge sys_clk);
    check("groups left", 264'(exp_q.size()), 264'h0);
  endtask

  // Watch outputs once settled after each edge
  always begin
    vpd_grp_t want;
    @(posedge sys_clk);
    #2;
    if (!rst && unit_issue != '0) begin
      want = (exp_q.size() > 0) ? exp_q.pop_front() : '0;
      check("unit_issue", unit_issue, want);
    end
  end

  // Hang guard, well beyond the expected run
  initial begin
    #200000;
    miscompares++;
    close_out();
  end

  // Main sequence
  initial begin
    logic [7:0]   ch;
    logic [255:0] dp;   // Directed packet after the second reset
    vpd_mem_t     mw;   // Expected store request
    rst = 1'b1;
    slow = 1'b0;
    miscompares = 0;
    n_compared = 0;
    void'($urandom(32'h6895825b));
    repeat (4) @(negedge sys_clk);
    rst <= 1'b0;
    @(negedge sys_clk);
    // Directed splits, duplicates and a run-through at slot seven
    foreach (dir[i]) push_pkt(mk_pkt(dir[i], i == 2));
    drain();
    // Random splits, prompt then slow memory
    for (int k = 0; k < 60; k++) begin
      slow <= k >= 30;
      ch = $urandom;
      ch[7] = 1'b0;
      push_pkt(mk_pkt(ch, 1'b0));
      if (k % 10 == 9) drain();
    end
    drain();
    slow <= 1'b0;
    // Reset in mid packet, then restart at slot zero
    push_pkt(mk_pkt(8'h00, 1'b0));
    repeat (5) @(negedge sys_clk);
    rst <= 1'b1;
    exp_q.delete();
    repeat (2) @(negedge sys_clk);
    rst <= 1'b0;
    @(negedge sys_clk);
    // Registers are zero again: store word at base zero, then branch
    // on the updated base, which must already hold the new address
    dp = '0;
    dp[F_UNIT+:2] = UNIT_DADDR;
    dp[F_OP+:3] = {1'b1, SZ_WORD};
    dp[F_OFF5+:5] = 5'h1;
    dp[32+F_UNIT+:2] = UNIT_SHBR;
    dp[32+F_OP+:3] = OP_BR;
    mw = '{valid: 1'b1, store: 1'b1, ben: 4'hF,
           addr: 32'h1 << SZ_WORD, wdata: 32'h0};
    push_pkt(dp);
    for (int n = 0; n < 20 && mem_req[0].valid !== 1'b1; n++)
      @(negedge sys_clk);
    check("mem_req", 264'(mem_req[0]), 264'(mw));
    @(negedge sys_clk);
    check("branch", 264'({branch_valid, branch_target}),
          264'({1'b1, 32'h1 << SZ_WORD}));
    push_pkt(mk_pkt(8'h81, 1'b0));
    drain();
    close_out();
  end
endmodule
